// ===== src/tsi_pkg.sv
// package for the stage 1 tlb invalidation block: opcodes, field layout, register map
package tsi_pkg;
  localparam int TSI_ENTRIES = 8;
  // command opcodes (low byte of word 0)
  localparam logic [7:0] OP_GUEST_ALL = 8'h10;
  localparam logic [7:0] OP_GUEST_ASID = 8'h11;
  localparam logic [7:0] OP_GUEST_VA = 8'h12;
  localparam logic [7:0] OP_GUEST_VAA = 8'h13;
  localparam logic [7:0] OP_MON_ALL = 8'h18;
  localparam logic [7:0] OP_MON_VA = 8'h1A;
  localparam logic [7:0] OP_HYP_ALL = 8'h20;
  localparam logic [7:0] OP_HYP_ASID = 8'h21;
  localparam logic [7:0] OP_HYP_VA = 8'h22;
  localparam logic [7:0] OP_HYP_VAA = 8'h23;
  localparam logic [7:0] OP_SYNC = 8'h46;
  // field positions
  localparam int SEC_FLAG_BIT = 10;
  localparam int LEAF_BIT = 0;
  localparam int VA_PAGE_LSB = 12;
  // register byte offsets
  localparam logic [11:0] REG_CMD0 = 12'h000;
  localparam logic [11:0] REG_CMD1 = 12'h004;
  localparam logic [11:0] REG_CMD2 = 12'h008;
  localparam logic [11:0] REG_CMD3 = 12'h00C;
  localparam logic [11:0] REG_ISSUE = 12'h010;
  localparam logic [11:0] REG_CTRL = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [11:0] REG_FILL0 = 12'h020;
  localparam logic [11:0] REG_FILL1 = 12'h024;
  localparam logic [11:0] REG_FILL2 = 12'h028;
  localparam logic [11:0] REG_BCAST = 12'h02C;
  // control register bit positions
  localparam int CTRL_WILD = 0;
  localparam int CTRL_HOST = 1;
  localparam int CTRL_S1 = 2;
  localparam int CTRL_S2 = 3;
  localparam int CTRL_HYP = 4;
  localparam int CTRL_WASID = 5;
  localparam int CTRL_WVMID = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0074;
  // stream worlds
  typedef enum logic [2:0] {
    WORLD_NS_EL1 = 3'h0,
    WORLD_SECURE = 3'h1,
    WORLD_EL3 = 3'h2,
    WORLD_EL2 = 3'h3,
    WORLD_EL2_HOST = 3'h4
  } tsi_world_t;
  // one tlb entry
  typedef struct packed {
    logic valid;
    logic locked;
    logic global_map;
    logic asid_set_flag;
    tsi_world_t stream_world_a;
    logic [15:0] asid;
    logic [15:0] vmid;
    logic [51:0] va_page;
    logic [3:0] size_log;
  } tsi_entry_t;
  // decoded command
  typedef struct packed {
    logic [7:0] opcode;
    logic security_flag;
    logic [15:0] asid;
    logic [15:0] vmid;
    logic [51:0] va_page;
    logic leaf;
    logic from_secure;
  } tsi_cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_APPLY = 2'b01,
    ST_DONE = 2'b11
  } tsi_state_t;
endpackage

// ===== src/tsi_tlb_inval.sv
// stage 1 tlb invalidation engine with apb register slave and small tlb
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tsi_tlb_inval
  import tsi_pkg::*;
#(
  parameter int ENTRIES = TSI_ENTRIES,
  parameter int VA_SIZE = 48
) (
  input wire logic CLK, // 10 mhz clock
  input wire logic RST_N, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic PREADY, // apb ready
  output logic [31:0] PRDATA, // apb read data
  output logic PSLVERR, // apb error
  output logic ILLEGAL_COMMAND_ERROR, // pulse on illegal command
  output logic SYNC_DONE // pulse when sync completes
);
  logic [31:0] cmd_w [4];
  logic [31:0] ctrl;
  logic [31:0] fill_w [3];
  tsi_entry_t tlb [ENTRIES];
  tsi_state_t state;
  tsi_cmd_t cur;
  logic busy_sync;
  logic err_sticky;
  logic [7:0] inval_count;
  logic wr_en; // access-phase write
  logic rd_en; // access-phase read
  logic issue_q; // accepted queue launch
  logic issue_s; // launch names the secure queue
  logic bcast; // accepted broadcast replay
  logic fill_go; // install strobe
  logic mapped; // address decodes to a register
  logic illegal; // latched command is refused
  logic is_sync; // latched command is a sync
  logic [ENTRIES-1:0] hit;
  logic va_bad;

  // register map, byte offsets on a 12-bit apb address
  //   0x000 command word 0: opcode in [7:0], security flag in [10]
  //   0x004 command word 1: vmid in [15:0], asid in [31:16]
  //   0x008 command word 2: leaf in [0], page bits in [31:12]
  //   0x00C command word 3: upper page bits
  //   0x010 issue: any write launches the staged command
  //         bit 0 set picks the secure queue, clear the non-secure one
  //   0x014 control: steers matching and legality
  //         bit 0 vmid wildcard, bit 1 el2 host mode
  //         bit 2 stage 1 present, bit 3 stage 2 present
  //         bit 4 hypervisor support
  //         bit 5 wide asid, bit 6 wide vmid
  //   0x018 status: bit 0 sticky error, write 1 clears
  //         bit 1 busy, bits [15:8] count of applied invalidations
  //   0x020 fill word 0: asid in [31:16], vmid in [15:0]
  //   0x024 fill word 1: middle page bits
  //   0x028 fill word 2: write installs an entry, read gives the valid map
  //         [2:0] index, 3 valid, 4 locked, 5 global, 6 asid set flag
  //         [9:7] world, [13:10] size, [31:20] top page bits
  //   0x02C broadcast: write replays the staged words as an incoming
  //         non-secure broadcast invalidation
  //   anything else answers with an error and reads zero
  //
  // world codes held per entry
  //   0 non-secure el1, 1 secure, 2 el3, 3 el2, 4 el2 host mode
  //
  // opcodes decoded
  //   0x10 guest all, 0x11 guest by asid
  //   0x12 guest by va, 0x13 guest by va for all asids
  //   0x18 monitor all, 0x1A monitor by va
  //   0x20 hyp all, 0x21 hyp by asid
  //   0x22 hyp by va, 0x23 hyp by va for all asids
  //   0x46 sync
  //
  // illegal command cases, each raising one error pulse
  //   stage 1 absent and any stage 1 invalidation
  //   monitor command arriving on the non-secure queue
  //   hyp command while hypervisor support is off
  //   security flag set on a non-secure launch
  //   any opcode not listed above
  //
  // broadcast replays carry no queue of their own and are treated as
  // non-secure; they obey the same legality checks as queued commands
  //
  // timing, counted from the access edge e of a launch write
  //   e+1: engine in apply, match lanes settle on the latched command
  //   e+1 edge: hits cleared, pulses registered
  //   e+2: engine in done, busy first visible
  //   e+3: engine idle again, next launch accepted
  // a launch that lands while busy is dropped without notice, so
  // software should poll busy or leave three cycles between launches
  //
  // why a single apply cycle: every entry compares in parallel, so the
  // whole tlb is swept at once; the cost is one comparator lane per
  // entry, which is why the entry count is kept small by default
  //
  // sync ordering: an invalidation finishes inside its own apply cycle,
  // so any sync issued after it finds nothing outstanding and can
  // report completion straight away
  //
  // locked entries never match; software that needs them gone must
  // rewrite them through the fill path with the lock bit clear
  //
  // narrow ids: when wide support is off, a command whose upper id
  // byte is non-zero skips every entry rather than guessing a match
  //
  // vmid wildcard: low four vmid bits are ignored while it is enabled
  //
  // va range: bits from the va size up to bit 55 must all agree with
  // the top valid bit; the top byte is never looked at
  //
  // leaf scope: every entry held here is a final-level entry, so the
  // leaf and non-leaf forms remove the same set
  //
  // a fill that meets an apply on the same entry loses to the apply
  // clear, so an invalidation cannot be undone by a racing install
  //
  // status count wraps at 255 and counts only applied invalidations;
  // illegal commands and syncs leave it alone
  //
  // reset clears every entry, the staged words and the status; the
  // control register comes up with stage 1, hyp and wide ids set
  //
  // read data is registered in the setup cycle and stands in access;
  // hit lanes are pure logic and only the apply cycle acts on them
  //
  // scope stays local: invalidations act only on the tlb held here; outward the block drives just the apb reply and the two pulses

  // apb decode: single wait-free access, unmapped reads zero with error
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  always_comb begin
    mapped = 1'b1;
    unique case (PADDR)
      REG_CMD0, REG_CMD1, REG_CMD2, REG_CMD3, REG_ISSUE, REG_CTRL, REG_STATUS,
      REG_FILL0, REG_FILL1, REG_FILL2, REG_BCAST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !mapped;
  // issue register: bit 0 selects the secure queue; busy engine drops the write
  assign issue_q = wr_en && PADDR == REG_ISSUE && state == ST_IDLE;
  assign issue_s = PWDATA[0];
  assign bcast = wr_en && PADDR == REG_BCAST && state == ST_IDLE;
  assign fill_go = wr_en && PADDR == REG_FILL2;

  // command word staging
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) cmd_w[i] <= 32'h0000_0000;
      for (int i = 0; i < 3; i++) fill_w[i] <= 32'h0000_0000;
    end else if (wr_en) begin
      if (PADDR == REG_CMD0) cmd_w[0] <= PWDATA;
      if (PADDR == REG_CMD1) cmd_w[1] <= PWDATA;
      if (PADDR == REG_CMD2) cmd_w[2] <= PWDATA;
      if (PADDR == REG_CMD3) cmd_w[3] <= PWDATA;
      if (PADDR == REG_FILL0) fill_w[0] <= PWDATA;
      if (PADDR == REG_FILL1) fill_w[1] <= PWDATA;
    end
  end

  // control register steers matching and legality
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ctrl <= CTRL_RESET;
    else if (wr_en && PADDR == REG_CTRL) ctrl <= PWDATA;
  end

  // decode: broadcast messages reuse the staged words as a non-secure command
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '0;
    end else if (issue_q || bcast) begin
      cur.opcode <= cmd_w[0][7:0];
      cur.security_flag <= cmd_w[0][SEC_FLAG_BIT];
      cur.vmid <= cmd_w[1][15:0];
      cur.asid <= cmd_w[1][31:16];
      cur.va_page <= {cmd_w[3], cmd_w[2][31:VA_PAGE_LSB]};
      cur.leaf <= cmd_w[2][LEAF_BIT];
      cur.from_secure <= issue_q ? issue_s : 1'b0;
    end
  end

  // legality checks
  always_comb begin
    illegal = 1'b0;
    is_sync = cur.opcode == OP_SYNC;
    if (cur.security_flag && !cur.from_secure) illegal = 1'b1;
    unique case (cur.opcode)
      OP_GUEST_ALL, OP_GUEST_ASID, OP_GUEST_VA, OP_GUEST_VAA:
        if (!ctrl[CTRL_S1]) illegal = 1'b1;
      OP_MON_ALL, OP_MON_VA:
        if (!ctrl[CTRL_S1] || !cur.from_secure) illegal = 1'b1;
      OP_HYP_ALL, OP_HYP_ASID, OP_HYP_VA, OP_HYP_VAA:
        if (!ctrl[CTRL_S1] || !ctrl[CTRL_HYP]) illegal = 1'b1;
      OP_SYNC: ;
      default: illegal = 1'b1;
    endcase
  end

  // out-of-range va: bits from va_size up (below top byte) must agree
  always_comb begin
    logic [63:0] full_va;
    full_va = {cur.va_page, 12'h000};
    va_bad = 1'b0;
    for (int b = VA_SIZE; b < 56; b++) // top byte ignored
      if (full_va[b] != full_va[VA_SIZE-1]) va_bad = 1'b1;
  end

  // per-entry match, one generate lane per entry
  for (genvar g = 0; g < ENTRIES; g++) begin : g_match
    always_comb begin
      logic asid_ok, vmid_ok, va_ok, narrow_bad, w_ok, use_vmid, is_va;
      logic [51:0] mask;
      tsi_entry_t e;
      asid_ok = 1'b0;
      vmid_ok = 1'b0;
      va_ok = 1'b0;
      narrow_bad = 1'b0;
      w_ok = 1'b0;
      use_vmid = 1'b0;
      is_va = 1'b0;
      mask = '0;
      e = tlb[g];
      // narrow ids compare low byte, nonzero upper byte skips
      narrow_bad = (!ctrl[CTRL_WASID] && cur.asid[15:8] != 8'h00) ||
                   (!ctrl[CTRL_WVMID] && cur.vmid[15:8] != 8'h00);
      asid_ok = ctrl[CTRL_WASID] ? e.asid == cur.asid : e.asid[7:0] == cur.asid[7:0];
      use_vmid = ctrl[CTRL_S2] && !cur.from_secure;
      // wildcard treats low vmid bits as don't care
      vmid_ok = !use_vmid ||
                (ctrl[CTRL_WILD] ? e.vmid[15:4] == cur.vmid[15:4] :
                 ctrl[CTRL_WVMID] ? e.vmid == cur.vmid : e.vmid[7:0] == cur.vmid[7:0]);
      mask = ~((52'h1 << e.size_log) - 52'h1);
      va_ok = (e.va_page & mask) == (cur.va_page & mask);
      // leaf form only keeps final entries; all entries modelled as leaf
      is_va = 1'b1;
      hit[g] = 1'b0;
      w_ok = 1'b0;
      unique case (cur.opcode)
        OP_GUEST_ALL: begin
          w_ok = cur.from_secure ? e.stream_world_a == WORLD_SECURE
                                 : e.stream_world_a == WORLD_NS_EL1;
          hit[g] = w_ok && vmid_ok;
        end
        OP_GUEST_ASID: begin
          w_ok = cur.from_secure ? e.stream_world_a == WORLD_SECURE
                                 : e.stream_world_a == WORLD_NS_EL1;
          hit[g] = w_ok && vmid_ok && asid_ok && !e.global_map;
        end
        OP_GUEST_VA, OP_GUEST_VAA: begin
          w_ok = cur.from_secure ? e.stream_world_a == WORLD_SECURE : e.stream_world_a == WORLD_NS_EL1;
          hit[g] = w_ok && vmid_ok && va_ok && is_va && !va_bad &&
                   (cur.opcode == OP_GUEST_VAA || asid_ok || e.global_map);
        end
        OP_MON_ALL: hit[g] = e.stream_world_a == WORLD_EL3;
        OP_MON_VA: hit[g] = e.stream_world_a == WORLD_EL3 && va_ok && !va_bad;
        OP_HYP_ALL: hit[g] = e.stream_world_a == WORLD_EL2 || e.stream_world_a == WORLD_EL2_HOST;
        OP_HYP_ASID, OP_HYP_VA, OP_HYP_VAA: begin
          // host mode selects which hyp world is in scope
          w_ok = ctrl[CTRL_HOST] ? e.stream_world_a == WORLD_EL2_HOST : e.stream_world_a == WORLD_EL2;
          hit[g] = w_ok && (cur.opcode == OP_HYP_ASID || (va_ok && !va_bad)) &&
                   (!ctrl[CTRL_HOST] || cur.opcode == OP_HYP_VAA || asid_ok || e.global_map);
        end
        default: hit[g] = 1'b0;
      endcase
      hit[g] = hit[g] && e.valid && !e.locked && !narrow_bad;
    end
  end

  // engine: idle, apply one cycle, done. all effects stay local.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) state <= ST_IDLE;
    else begin
      unique case (state)
        ST_IDLE: if (issue_q || bcast) state <= ST_APPLY;
        ST_APPLY: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE; // unused code recovers to idle
      endcase
    end
  end

  // tlb storage: fill via registers, clear on hit in apply
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < ENTRIES; i++) tlb[i] <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (state == ST_APPLY && !illegal && hit[i]) tlb[i].valid <= 1'b0;
        else if (fill_go && PWDATA[2:0] == i[2:0]) begin
          tlb[i].valid <= PWDATA[3];
          tlb[i].locked <= PWDATA[4];
          tlb[i].global_map <= PWDATA[5];
          tlb[i].asid_set_flag <= PWDATA[6];
          tlb[i].stream_world_a <= tsi_world_t'(PWDATA[9:7]);
          tlb[i].size_log <= PWDATA[13:10];
          tlb[i].asid <= fill_w[0][31:16];
          tlb[i].vmid <= fill_w[0][15:0];
          tlb[i].va_page <= {PWDATA[31:20], fill_w[1], 8'h00};
        end
      end
    end
  end

  // results: invalidation lands in apply, so a sync after it is always ordered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ILLEGAL_COMMAND_ERROR <= 1'b0;
      SYNC_DONE <= 1'b0;
      err_sticky <= 1'b0;
      inval_count <= 8'h00;
      busy_sync <= 1'b0;
    end else begin
      ILLEGAL_COMMAND_ERROR <= state == ST_APPLY && illegal;
      SYNC_DONE <= state == ST_APPLY && is_sync;
      busy_sync <= state != ST_IDLE;
      if (state == ST_APPLY && illegal) err_sticky <= 1'b1; // set wins over clear
      else if (wr_en && PADDR == REG_STATUS && PWDATA[0]) err_sticky <= 1'b0;
      if (state == ST_APPLY && !illegal && !is_sync) inval_count <= inval_count + 8'h01;
    end
  end

  // read mux
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        REG_CMD0: PRDATA <= cmd_w[0];
        REG_CMD1: PRDATA <= cmd_w[1];
        REG_CMD2: PRDATA <= cmd_w[2];
        REG_CMD3: PRDATA <= cmd_w[3];
        REG_CTRL: PRDATA <= ctrl;
        REG_STATUS: PRDATA <= {16'h0000, inval_count, 6'h00, busy_sync, err_sticky};
        REG_FILL0: PRDATA <= fill_w[0];
        REG_FILL1: PRDATA <= fill_w[1];
        REG_FILL2: begin
          PRDATA <= 32'h0000_0000;
          for (int i = 0; i < ENTRIES; i++) PRDATA[i] <= tlb[i].valid;
        end
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/tsi_tlb_inval_sva.sv
// port checker for the tlb invalidation block
`timescale 1ns/1ps
`default_nettype none
module tsi_tlb_inval_sva
  import tsi_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic RST_N, // reset, active low
  input wire logic PSEL, // select
  input wire logic PENABLE, // access phase
  input wire logic PWRITE, // direction
  input wire logic [11:0] PADDR, // address
  input wire logic [31:0] PWDATA, // write data
  input wire logic PREADY, // ready
  input wire logic [31:0] PRDATA, // read data
  input wire logic PSLVERR, // bus error
  input wire logic ILLEGAL_COMMAND_ERROR, // error pulse
  input wire logic SYNC_DONE // sync pulse
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic acc, iss, mapped;
  // a launch is any access write to the issue or broadcast word
  assign acc = PSEL && PENABLE;
  assign iss = acc && PWRITE && (PADDR == REG_ISSUE || PADDR == REG_BCAST);
  assign mapped = PADDR <= REG_STATUS || (PADDR >= REG_FILL0 && PADDR <= REG_BCAST);
  a_err_needs_launch: assert property (ILLEGAL_COMMAND_ERROR |-> $past(iss, 2))
    else $error("error pulse without launch");
  a_sync_needs_launch: assert property (SYNC_DONE |-> $past(iss, 2))
    else $error("sync pulse without launch");
  a_sync_one_cycle: assert property ($rose(SYNC_DONE) |=> $fell(SYNC_DONE))
    else $error("sync pulse too long");
  a_one_outcome: assert property (!(ILLEGAL_COMMAND_ERROR && SYNC_DONE))
    else $error("error and sync together");
  a_pulse_gap: assert property ((ILLEGAL_COMMAND_ERROR || SYNC_DONE) |=>
    !(ILLEGAL_COMMAND_ERROR || SYNC_DONE) [*2])
    else $error("pulses too close");
  a_unmapped_err: assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  a_ready_high: assert property (PREADY)
    else $error("wait state seen");
  c_err: cover property (iss ##2 ILLEGAL_COMMAND_ERROR);
  c_sync: cover property (iss ##2 SYNC_DONE);
  c_slverr: cover property (acc && PSLVERR);
endmodule
bind tsi_tlb_inval tsi_tlb_inval_sva chk_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .ILLEGAL_COMMAND_ERROR(ILLEGAL_COMMAND_ERROR), .SYNC_DONE(SYNC_DONE));
`default_nettype wire

// ===== tb/tsi_cmd_queue.sv
// software command queue model: apb master that posts commands
`timescale 1ns/1ps
`default_nettype none
module tsi_cmd_queue
  import tsi_pkg::*;
(
  input wire logic clk, // clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [11:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr // bus error
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer, request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines must not keep the old value
    pwdata <= ~d;
  endtask
  // post command words then launch on the chosen queue
  task automatic issue(input logic [11:0] a, input logic [31:0] w0, input logic [31:0] w1, input logic sec);
    logic [31:0] q;
    logic e;
    xfer(1'b1, REG_CMD0, w0, q, e);
    xfer(1'b1, REG_CMD1, w1, q, e);
    xfer(1'b1, a, {31'h0, sec}, q, e);
  endtask
endmodule
`default_nettype wire

// ===== tb/tsi_tlb_inval_tb.sv
// testbench for the stage 1 tlb invalidation block
`timescale 1ns/1ps
`default_nettype none
module tsi_tlb_inval_tb
  import tsi_pkg::*;
;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ILLEGAL_COMMAND_ERROR, SYNC_DONE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic e;
  int errors = 0;
  int check_count = 0;
  int err_seen = 0;
  int sync_seen = 0;
  tsi_tlb_inval #(.ENTRIES(8)) tsi_tlb_inval_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .ILLEGAL_COMMAND_ERROR(ILLEGAL_COMMAND_ERROR), .SYNC_DONE(SYNC_DONE));
  tsi_cmd_queue cq_i (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR));
  always #50 CLK = ~CLK;
  // pulses last one cycle, so count them at every edge
  always @(posedge CLK) begin
    if (ILLEGAL_COMMAND_ERROR === 1'b1)
      err_seen <= err_seen + 1;
    if (SYNC_DONE === 1'b1)
      sync_seen <= sync_seen + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cq_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
    cq_i.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_e});
  endtask
  // install an entry; asid_set_flag is always set so asid matches must ignore it
  task automatic fill(input logic [2:0] i, input logic [2:0] w, input logic g, input logic [15:0] asid,
    input logic [15:0] vmid);
    wr(REG_FILL0, {asid, vmid});
    wr(REG_FILL2, {22'h0, w, 1'b1, g, 1'b0, 1'b1, i});
  endtask
  // launch, wait four cycles for the engine, then count pulses and read the valid map
  task automatic run(input logic [11:0] a, input logic [31:0] w0, input logic [31:0] w1, input logic sec,
    input logic [1:0] n_err, input logic [1:0] n_sync, input logic [7:0] map);
    int e0;
    int s0;
    e0 = err_seen;
    s0 = sync_seen;
    cq_i.issue(a, w0, w1, sec);
    repeat (4) @(posedge CLK);
    chk(32'(err_seen - e0), {30'h0, n_err});
    chk(32'(sync_seen - s0), {30'h0, n_sync});
    rd(REG_FILL2, {24'h0, map}, 1'b0);
  endtask
  task automatic t_reset;
    rd(REG_CTRL, CTRL_RESET, 1'b0);
    rd(REG_STATUS, 32'h0, 1'b0);
    rd(12'h01C, 32'h0, 1'b1);
  endtask
  task automatic t_ns_all;
    wr(REG_CTRL, 32'h0000007C); // stage 2 on so vmid takes part
    fill(3'h0, WORLD_NS_EL1, 1'b1, 16'h0003, 16'h0005);
    fill(3'h1, WORLD_NS_EL1, 1'b0, 16'h0003, 16'h0005);
    fill(3'h2, WORLD_NS_EL1, 1'b0, 16'h0003, 16'h0006);
    fill(3'h3, WORLD_SECURE, 1'b0, 16'h0003, 16'h0000);
    fill(3'h4, WORLD_EL3, 1'b0, 16'h0003, 16'h0000);
    fill(3'h5, WORLD_EL2, 1'b0, 16'h0003, 16'h0000);
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL}, 32'h00000005, 1'b0, 2'h0, 2'h0, 8'h3C);
  endtask
  task automatic t_ns_asid;
    fill(3'h0, WORLD_NS_EL1, 1'b0, 16'h0003, 16'h0005);
    fill(3'h1, WORLD_NS_EL1, 1'b1, 16'h0003, 16'h0005);
    fill(3'h6, WORLD_NS_EL1, 1'b0, 16'h0004, 16'h0005);
    run(REG_ISSUE, {24'h0, OP_GUEST_ASID}, 32'h00030005, 1'b0, 2'h0, 2'h0, 8'h7E);
  endtask
  task automatic t_secure;
    fill(3'h7, WORLD_SECURE, 1'b1, 16'h0003, 16'h0000);
    run(REG_ISSUE, {24'h0, OP_GUEST_ASID}, 32'h00030000, 1'b1, 2'h0, 2'h0, 8'hF6);
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL}, 32'h0, 1'b1, 2'h0, 2'h0, 8'h76);
  endtask
  task automatic t_monitor;
    run(REG_ISSUE, {24'h0, OP_MON_ALL}, 32'h0, 1'b0, 2'h1, 2'h0, 8'h76);
    run(REG_ISSUE, {24'h0, OP_MON_ALL}, 32'h0, 1'b1, 2'h0, 2'h0, 8'h66);
  endtask
  task automatic t_sec_flag;
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL} | 32'h00000400, 32'h00000006, 1'b0, 2'h1, 2'h0, 8'h66);
  endtask
  task automatic t_hyp;
    run(REG_ISSUE, {24'h0, OP_HYP_ALL}, 32'h0, 1'b0, 2'h0, 2'h0, 8'h46);
    wr(REG_CTRL, 32'h0000006C);
    run(REG_ISSUE, {24'h0, OP_HYP_ALL}, 32'h0, 1'b0, 2'h1, 2'h0, 8'h46);
  endtask
  task automatic t_stage2_only;
    wr(REG_CTRL, 32'h00000068);
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL}, 32'h00000006, 1'b0, 2'h1, 2'h0, 8'h46);
  endtask
  task automatic t_sync_bcast;
    run(REG_ISSUE, {24'h0, OP_SYNC}, 32'h0, 1'b0, 2'h0, 2'h1, 8'h46);
    wr(REG_CTRL, 32'h0000007C);
    run(REG_BCAST, {24'h0, OP_GUEST_ASID}, 32'h00040005, 1'b0, 2'h0, 2'h0, 8'h06);
  endtask
  // narrow ids refuse a non-zero upper byte; wildcard drops low vmid bits
  task automatic t_narrow_wild;
    wr(REG_CTRL, 32'h0000001C);
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL}, 32'h00000106, 1'b0, 2'h0, 2'h0, 8'h06);
    wr(REG_CTRL, 32'h0000001D);
    run(REG_ISSUE, {24'h0, OP_GUEST_ALL}, 32'h00000003, 1'b0, 2'h0, 2'h0, 8'h00);
    rd(REG_STATUS, 32'h00000901, 1'b0);
    wr(REG_STATUS, 32'h00000001);
    rd(REG_STATUS, 32'h00000900, 1'b0);
  endtask
  task automatic test_done;
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_ns_all();
    t_ns_asid();
    t_secure();
    t_monitor();
    t_sec_flag();
    t_hyp();
    t_stage2_only();
    t_sync_bcast();
    t_narrow_wild();
    test_done();
  end
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
